// file: hdl/uart_channel_register_decode.sv
// Register decoder for both channels of a dual UART.
// Host pins are synchronised to clk; receive bytes sit in a FIFO.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Own register set per channel; a low select picks it.
// - Offset 0, divisor off: read oldest byte, write transmits.
// - Divisor on, bank not BF: offsets 0/1 are divisor low/high.
// - Offset 2, bank not BF: fraction with divisor on and enhanced enable.
// - Fraction keeps bits 3..0; upper four bits read as zero.
// - Divisor on and zero, bank not BF: offsets 0/1 read revision/identity.
// - Divisor off: offset 1 is interrupt enable.
// - Bank not BF: offset 2 reads interrupt status, writes FIFO control.
// - Offset 3 always reaches line control.
// - Bank not BF: offset 4 is modem control.
// - Bank not BF: offset 5 reads line status, offset 6 modem status.
// - Normal bank ignores writes to offset 6.
// - Offset 7, swap bit clear: plain scratch byte.
// - Offset 7, swap set: read gives a fill level.
// - Offset 7, swap set: write loads mode select only.
// - Bank BF: offset 0 writes trigger level, reads level count.
// - Bank BF: offset 1 is feature control.
// - Bank BF: offset 2 is enhanced function.
// - Bank BF: offsets 4..7 are resume 1, resume 2, stop 1, stop 2.
module uart_channel_register_decode
    import uart_decode_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH,
    parameter logic [7:0] REVISION_VALUE = 8'h01, // Arbitrary value
    parameter logic [7:0] IDENTITY_VALUE = 8'h5C  // Arbitrary value
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [ADDR_WIDTH-1:0] address_pin,
    input wire logic chan_a_select_n,
    input wire logic chan_b_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [DATA_WIDTH-1:0] data_pin_in,
    output logic [DATA_WIDTH-1:0] data_pin_out,
    output logic data_pin_oe,
    input wire logic [CHANNELS-1:0] rx_char_valid,
    input wire logic [CHANNELS-1:0][7:0] rx_char,
    output logic [CHANNELS-1:0] rx_char_ready,
    output logic [CHANNELS-1:0] tx_char_valid,
    output logic [CHANNELS-1:0][7:0] tx_char,
    input wire logic [CHANNELS-1:0][7:0] interrupt_status,
    input wire logic [CHANNELS-1:0][7:0] line_status,
    input wire logic [CHANNELS-1:0][7:0] modem_status,
    input wire logic [CHANNELS-1:0][7:0] tx_fill_level,
    output channel_regs_type [CHANNELS-1:0] channel_regs,
    output logic [CHANNELS-1:0][7:0] fifo_control,
    output logic [CHANNELS-1:0] fifo_control_load,
    output logic [CHANNELS-1:0][7:0] fifo_trigger_level,
    output logic [CHANNELS-1:0] fifo_trigger_load,
    output logic [CHANNELS-1:0][7:0] extended_mode_select,
    output logic [CHANNELS-1:0] extended_mode_load
);
    localparam int FILL_WIDTH = $clog2(DEPTH) + 1;
    localparam logic [3:0] STROBE_IDLE = 4'hF;
    localparam logic [10:0] BUS_IDLE = 11'h000;

    typedef struct packed {
        channel_regs_type [CHANNELS-1:0] regs;
        logic [CHANNELS-1:0][7:0] fifo_control;
        logic [CHANNELS-1:0][7:0] trigger_level;
        logic [CHANNELS-1:0][7:0] mode_select;
        logic [CHANNELS-1:0][7:0] tx_char;
        logic [CHANNELS-1:0] fifo_control_load;
        logic [CHANNELS-1:0] trigger_load;
        logic [CHANNELS-1:0] mode_load;
        logic [CHANNELS-1:0] tx_valid;
        logic [7:0] data_out;
        logic data_oe;
        logic read_prev_n;
        logic write_prev_n;
    } decode_state_type;

    decode_state_type state;
    decode_state_type next_state;

    logic [3:0] strobes;
    logic [10:0] bus_pins;
    logic sel_a_n;
    logic sel_b_n;
    logic rd_n;
    logic wr_n;
    logic [ADDR_WIDTH-1:0] offset;
    logic [7:0] wdata;
    logic [CHANNELS-1:0] rx_pop;
    logic [CHANNELS-1:0] rx_avail;
    logic [CHANNELS-1:0][7:0] rx_head;
    logic [CHANNELS-1:0][FILL_WIDTH-1:0] rx_fill;

    // Strobes idle high, bus lines idle low
    pin_synchronizer #(.WIDTH(4), .RESET_VALUE(STROBE_IDLE)) strobe_sync (
        .clk(clk),
        .rstn(rstn),
        .pin_in({chan_a_select_n, chan_b_select_n, read_strobe_n,
                 write_strobe_n}),
        .stable_out(strobes)
    );

    pin_synchronizer #(.WIDTH(11), .RESET_VALUE(BUS_IDLE)) bus_sync (
        .clk(clk),
        .rstn(rstn),
        .pin_in({address_pin, data_pin_in}),
        .stable_out(bus_pins)
    );

    assign {sel_a_n, sel_b_n, rd_n, wr_n} = strobes;
    assign {offset, wdata} = bus_pins;

    // One receive FIFO per channel; a full FIFO stalls the receiver
    for (genvar c = 0; c < CHANNELS; c++) begin : g_rx
        byte_fifo #(.WIDTH(8), .DEPTH(DEPTH)) rx_fifo (
            .clk(clk),
            .rstn(rstn),
            .in_valid(rx_char_valid[c]),
            .in_data(rx_char[c]),
            .in_ready(rx_char_ready[c]),
            .out_valid(rx_avail[c]),
            .out_data(rx_head[c]),
            .out_ready(rx_pop[c]),
            .fill_count(rx_fill[c])
        );
    end

    // Decode one access per strobe falling edge
    always_comb begin
        logic chan;
        logic selected;
        logic read_start;
        logic write_start;
        logic divisor_on;
        logic bank_bf;
        logic enhanced;
        logic swapped;
        logic divisor_zero;
        logic [7:0] level;
        logic [7:0] rdata;
        channel_regs_type r;

        next_state = state;
        next_state.fifo_control_load = '0;
        next_state.trigger_load = '0;
        next_state.mode_load = '0;
        next_state.tx_valid = '0;
        next_state.read_prev_n = rd_n;
        next_state.write_prev_n = wr_n;
        rx_pop = '0;

        // Both selects low is a host fault and reaches neither channel
        chan = !sel_b_n;
        selected = sel_a_n ^ sel_b_n;
        read_start = selected && !rd_n && state.read_prev_n;
        write_start = selected && !wr_n && state.write_prev_n;

        r = state.regs[chan];
        divisor_on = r.line_control[DIVISOR_ENABLE_BIT];
        bank_bf = r.line_control == BANK_SELECT_VALUE;
        enhanced = r.enhanced_function[ENHANCED_ENABLE_BIT];
        swapped = r.feature_control[SCRATCH_SWAP_BIT];
        divisor_zero = r.divisor_low == ZERO_BYTE &&
                       r.divisor_high == ZERO_BYTE;
        // Direction bit set picks transmit level
        level = r.feature_control[LEVEL_DIRECTION_BIT] ?
                tx_fill_level[chan] : 8'(rx_fill[chan]);

        // Read multiplexer
        rdata = ZERO_BYTE;
        unique case (offset)
            OFFSET_HOLDING: begin
                if (bank_bf) begin
                    rdata = level;
                end else if (divisor_on) begin
                    rdata = divisor_zero ? REVISION_VALUE
                                         : r.divisor_low;
                end else begin
                    rdata = rx_avail[chan] ? rx_head[chan] : ZERO_BYTE;
                end
            end
            OFFSET_ENABLE: begin
                if (bank_bf) begin
                    rdata = r.feature_control;
                end else if (divisor_on) begin
                    rdata = divisor_zero ? IDENTITY_VALUE
                                         : r.divisor_high;
                end else begin
                    rdata = r.interrupt_enable;
                end
            end
            OFFSET_STATUS_CTRL: begin
                if (bank_bf) begin
                    rdata = r.enhanced_function;
                end else if (divisor_on && enhanced) begin
                    rdata = r.divisor_fraction & FRACTION_MASK;
                end else begin
                    rdata = interrupt_status[chan];
                end
            end
            OFFSET_LINE_CONTROL: begin
                rdata = r.line_control;
            end
            OFFSET_MODEM_CONTROL: begin
                rdata = bank_bf ? r.resume_char_1 : r.modem_control;
            end
            OFFSET_LINE_STATUS: begin
                rdata = bank_bf ? r.resume_char_2 : line_status[chan];
            end
            OFFSET_MODEM_STATUS: begin
                rdata = bank_bf ? r.stop_char_1 : modem_status[chan];
            end
            OFFSET_SCRATCH: begin
                if (bank_bf) begin
                    rdata = r.stop_char_2;
                end else if (swapped) begin
                    rdata = level;
                end else begin
                    rdata = r.scratch_byte;
                end
            end
        endcase

        // Read data held until the strobe lifts
        if (read_start) begin
            next_state.data_out = rdata;
            next_state.data_oe = 1'b1;
            if (offset == OFFSET_HOLDING && !divisor_on && !bank_bf) begin
                rx_pop[chan] = 1'b1;
            end
        end else if (rd_n || !selected) begin
            next_state.data_oe = 1'b0;
        end

        // Write steering
        if (write_start) begin
            unique case (offset)
                OFFSET_HOLDING: begin
                    if (bank_bf) begin
                        next_state.trigger_level[chan] = wdata;
                        next_state.trigger_load[chan] = 1'b1;
                    end else if (divisor_on) begin
                        r.divisor_low = wdata;
                    end else begin
                        next_state.tx_char[chan] = wdata;
                        next_state.tx_valid[chan] = 1'b1;
                    end
                end
                OFFSET_ENABLE: begin
                    if (bank_bf) begin
                        r.feature_control = wdata;
                    end else if (divisor_on) begin
                        r.divisor_high = wdata;
                    end else if (enhanced) begin
                        r.interrupt_enable = wdata;
                    end else begin
                        // Upper bits locked unless enhanced
                        r.interrupt_enable = (wdata & ~IER_ENHANCED_MASK) |
                            (r.interrupt_enable & IER_ENHANCED_MASK);
                    end
                end
                OFFSET_STATUS_CTRL: begin
                    if (bank_bf) begin
                        r.enhanced_function = wdata;
                    end else if (divisor_on && enhanced) begin
                        r.divisor_fraction = wdata & FRACTION_MASK;
                    end else begin
                        next_state.fifo_control[chan] = wdata;
                        next_state.fifo_control_load[chan] = 1'b1;
                    end
                end
                OFFSET_LINE_CONTROL: begin
                    r.line_control = wdata;
                end
                OFFSET_MODEM_CONTROL: begin
                    if (bank_bf) begin
                        r.resume_char_1 = wdata;
                    end else if (enhanced) begin
                        r.modem_control = wdata;
                    end else begin
                        r.modem_control = (wdata & ~MCR_ENHANCED_MASK) |
                            (r.modem_control & MCR_ENHANCED_MASK);
                    end
                end
                OFFSET_LINE_STATUS: begin
                    if (bank_bf) begin
                        r.resume_char_2 = wdata;
                    end
                end
                OFFSET_MODEM_STATUS: begin
                    // Normal bank drops the write
                    if (bank_bf) begin
                        r.stop_char_1 = wdata;
                    end
                end
                OFFSET_SCRATCH: begin
                    if (bank_bf) begin
                        r.stop_char_2 = wdata;
                    end else if (swapped) begin
                        next_state.mode_select[chan] = wdata;
                        next_state.mode_load[chan] = 1'b1;
                    end else begin
                        r.scratch_byte = wdata;
                    end
                end
            endcase
            next_state.regs[chan] = r;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= '0;
            state.read_prev_n <= 1'b1;
            state.write_prev_n <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    // Registered outputs
    assign data_pin_out = state.data_out;
    assign data_pin_oe = state.data_oe;
    assign tx_char_valid = state.tx_valid;
    assign tx_char = state.tx_char;
    assign channel_regs = state.regs;
    assign fifo_control = state.fifo_control;
    assign fifo_control_load = state.fifo_control_load;
    assign fifo_trigger_level = state.trigger_level;
    assign fifo_trigger_load = state.trigger_load;
    assign extended_mode_select = state.mode_select;
    assign extended_mode_load = state.mode_load;
endmodule
`default_nettype wire

// file: hdl/uart_decode_pkg.sv
// Shared constants and types for the channel register decoder.
// Assumes a single clock domain and an 8-bit host data bus.
package uart_decode_pkg;

    // Register offsets on the three address lines
    localparam logic [2:0] OFFSET_HOLDING = 3'h0;
    localparam logic [2:0] OFFSET_ENABLE = 3'h1;
    localparam logic [2:0] OFFSET_STATUS_CTRL = 3'h2;
    localparam logic [2:0] OFFSET_LINE_CONTROL = 3'h3;
    localparam logic [2:0] OFFSET_MODEM_CONTROL = 3'h4;
    localparam logic [2:0] OFFSET_LINE_STATUS = 3'h5;
    localparam logic [2:0] OFFSET_MODEM_STATUS = 3'h6;
    localparam logic [2:0] OFFSET_SCRATCH = 3'h7;

    // Special values and masks
    localparam logic [7:0] BANK_SELECT_VALUE = 8'hBF;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] FRACTION_MASK = 8'h0F;
    localparam logic [7:0] IER_ENHANCED_MASK = 8'hF0;
    localparam logic [7:0] MCR_ENHANCED_MASK = 8'hE0;

    // Field positions
    localparam int DIVISOR_ENABLE_BIT = 7;
    localparam int ENHANCED_ENABLE_BIT = 4;
    localparam int SCRATCH_SWAP_BIT = 6;
    localparam int LEVEL_DIRECTION_BIT = 7;

    // Structure
    localparam int CHANNELS = 2;
    localparam int DATA_WIDTH = 8;
    localparam int ADDR_WIDTH = 3;
    localparam int FIFO_DEPTH = 32;

    // Writable configuration of one channel
    typedef struct packed {
        logic [7:0] divisor_low;
        logic [7:0] divisor_high;
        logic [7:0] divisor_fraction;
        logic [7:0] interrupt_enable;
        logic [7:0] line_control;
        logic [7:0] modem_control;
        logic [7:0] scratch_byte;
        logic [7:0] feature_control;
        logic [7:0] enhanced_function;
        logic [7:0] resume_char_1;
        logic [7:0] resume_char_2;
        logic [7:0] stop_char_1;
        logic [7:0] stop_char_2;
    } channel_regs_type;

endpackage

// file: hdl/pin_synchronizer.sv
// Three-stage synchroniser for a group of pins.
// A bit changes once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module pin_synchronizer #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] stable_out
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
        logic [WIDTH-1:0] stage3;
        logic [WIDTH-1:0] stable;
    } sync_state_type;

    sync_state_type state;
    sync_state_type next_state;

    // Only stage two reads stage one, to contain metastability
    always_comb begin
        next_state.stage1 = pin_in;
        next_state.stage2 = state.stage1;
        next_state.stage3 = state.stage2;
        next_state.stable = (state.stage2 & state.stage3) |
                            (state.stable & (state.stage2 | state.stage3));
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= {4{RESET_VALUE}};
        end else begin
            state <= next_state;
        end
    end

    assign stable_out = state.stable;
endmodule
`default_nettype wire

// file: hdl/byte_fifo.sv
// Synchronous FIFO with valid/ready on both sides and a fill count.
// Full and empty are registered, so in_ready and out_valid come from flops.
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready,
    output logic [$clog2(DEPTH):0] fill_count
);
    localparam int PTR_WIDTH = $clog2(DEPTH);

    typedef struct packed {
        logic [PTR_WIDTH-1:0] write_ptr;
        logic [PTR_WIDTH-1:0] read_ptr;
        logic [PTR_WIDTH:0] count;
        logic full;
        logic empty;
    } fifo_state_type;

    fifo_state_type state;
    fifo_state_type next_state;
    logic [WIDTH-1:0] storage [DEPTH];
    logic push;
    logic pop;

    assign push = in_valid && !state.full;
    assign pop = out_ready && !state.empty;

    // Pointers wrap; DEPTH must be a power of two
    always_comb begin
        next_state = state;
        if (push) begin
            next_state.write_ptr = state.write_ptr + 1'b1;
        end
        if (pop) begin
            next_state.read_ptr = state.read_ptr + 1'b1;
        end
        if (push && !pop) begin
            next_state.count = state.count + 1'b1;
        end else if (pop && !push) begin
            next_state.count = state.count - 1'b1;
        end
        next_state.full = next_state.count == (PTR_WIDTH + 1)'(DEPTH);
        next_state.empty = next_state.count == '0;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= '{write_ptr: '0, read_ptr: '0, count: '0,
                       full: 1'b0, empty: 1'b1};
        end else begin
            state <= next_state;
        end
    end

    // No reset on storage keeps it plain RAM
    always_ff @(posedge clk) begin
        if (push) begin
            storage[state.write_ptr] <= in_data;
        end
    end

    assign in_ready = !state.full;
    assign out_valid = !state.empty;
    assign out_data = storage[state.read_ptr];
    assign fill_count = state.count;
endmodule
`default_nettype wire

// file: testbench/uart_decode_checker.sv
// Assertions on the read enable and on channel A of the register decoder.
// Bound to the decoder; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module uart_decode_checker
    import uart_decode_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [ADDR_WIDTH-1:0] address_pin,
    input wire logic chan_a_select_n,
    input wire logic chan_b_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic data_pin_oe,
    input wire logic [CHANNELS-1:0] tx_char_valid,
    input wire channel_regs_type [CHANNELS-1:0] channel_regs,
    input wire logic [CHANNELS-1:0] fifo_control_load,
    input wire logic [CHANNELS-1:0] fifo_trigger_load,
    input wire logic [CHANNELS-1:0] extended_mode_load
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // tx and oe trace to a held, steered strobe; fcr and trigger loads to a held strobe
    a_oe_one_select: assert property (
        $rose(data_pin_oe) |-> !read_strobe_n &&
        chan_a_select_n != chan_b_select_n)
        else $error("oe without one read select");
    a_oe_released: assert property (
        $rose(read_strobe_n) |-> ##[1:8] !data_pin_oe)
        else $error("oe held after the read");
    a_tx_one_cycle: assert property (
        tx_char_valid[0] |=> !tx_char_valid[0])
        else $error("long tx pulse");
    a_tx_cause: assert property (
        tx_char_valid[0] |-> !write_strobe_n && !chan_a_select_n &&
        address_pin == OFFSET_HOLDING &&
        !channel_regs[0].line_control[DIVISOR_ENABLE_BIT])
        else $error("tx pulse without its write");
    a_fcr_cause: assert property (
        fifo_control_load[0] |-> !write_strobe_n &&
        address_pin == OFFSET_STATUS_CTRL &&
        channel_regs[0].line_control != BANK_SELECT_VALUE)
        else $error("stray fcr load");
    a_trig_cause: assert property (
        fifo_trigger_load[0] |-> !write_strobe_n &&
        address_pin == OFFSET_HOLDING &&
        channel_regs[0].line_control == BANK_SELECT_VALUE)
        else $error("stray trigger load");
    a_mode_keeps_pad: assert property (
        extended_mode_load[0] |->
        channel_regs[0].feature_control[SCRATCH_SWAP_BIT] &&
        $stable(channel_regs[0].scratch_byte))
        else $error("mode load hit scratch");
    a_fraction_nibble: assert property (
        (channel_regs[0].divisor_fraction & ~FRACTION_MASK) == ZERO_BYTE)
        else $error("fraction high bits set");
    a_lcr_write_only: assert property (
        !$stable(channel_regs[0].line_control) |-> !write_strobe_n &&
        !chan_a_select_n && address_pin == OFFSET_LINE_CONTROL)
        else $error("stray lcr change");
endmodule

bind uart_channel_register_decode uart_decode_checker i_uart_decode_checker (
    .clk, .rstn, .address_pin, .chan_a_select_n, .chan_b_select_n,
    .read_strobe_n, .write_strobe_n, .data_pin_oe, .tx_char_valid,
    .channel_regs, .fifo_control_load, .fifo_trigger_load,
    .extended_mode_load);
`default_nettype wire

// file: testbench/host_bus_model.sv
// Host model making single accesses on the 8-bit bus.
// A read is answered by data_pin_oe.
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
    input wire logic clk,
    input wire logic data_pin_oe,
    input wire logic [7:0] data_pin_out,
    output logic [2:0] address_pin,
    output logic chan_a_select_n,
    output logic chan_b_select_n,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output wire logic [7:0] data_pin_in
);
    logic [7:0] host_data = 8'h00;
    logic host_drive = 1'b0;
    // Undriven bus shows the inverse of the last byte
    assign data_pin_in = host_drive ? host_data :
        (data_pin_oe ? data_pin_out : ~host_data);
    // Idle bus at time zero
    initial begin
        address_pin = 3'h0;
        chan_a_select_n = 1'b1;
        chan_b_select_n = 1'b1;
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
    end
    // One access; sel_n is {B, A}
    task automatic xfer(input logic wr, input logic [1:0] sel_n,
        input logic [2:0] addr, input logic [7:0] wdata,
        output logic [7:0] rdata, output logic ok);
        int n = 0;
        @(posedge clk);
        address_pin <= addr;
        chan_a_select_n <= sel_n[0];
        chan_b_select_n <= sel_n[1];
        host_data <= wdata;
        host_drive <= wr;
        repeat (4) @(posedge clk);
        write_strobe_n <= !wr;
        read_strobe_n <= wr;
        if (wr) begin
            repeat (8) @(posedge clk);
        end else begin
            while (data_pin_oe !== 1'b1 && n < 20) begin
                @(posedge clk);
                n++;
            end
        end
        rdata = data_pin_out;
        ok = wr || data_pin_oe === 1'b1;
        write_strobe_n <= 1'b1;
        read_strobe_n <= 1'b1;
        chan_a_select_n <= 1'b1;
        chan_b_select_n <= 1'b1;
        host_drive <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// file: testbench/tb.sv
// Self-checking bench for the register decoder.
// Needs the host model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import uart_decode_pkg::*;
    logic clk, rstn, chan_a_select_n, chan_b_select_n, data_pin_oe;
    logic read_strobe_n, write_strobe_n;
    logic [2:0] address_pin;
    logic [7:0] data_pin_in, data_pin_out, q, tx_last;
    logic [1:0] rx_char_valid, rx_char_ready, tx_char_valid;
    logic [1:0] fifo_control_load, fifo_trigger_load, extended_mode_load;
    logic [1:0][7:0] rx_char, tx_char, fifo_control, fifo_trigger_level,
        extended_mode_select;
    logic [1:0][7:0] interrupt_status = {8'hC2, 8'hC1};
    logic [1:0][7:0] line_status = {8'h61, 8'h60};
    logic [1:0][7:0] modem_status = {8'h3C, 8'h3B};
    logic [1:0][7:0] tx_fill_level = {8'h2E, 8'h2D};
    channel_regs_type [1:0] channel_regs;
    int bad_count = 0, comparisons = 0, pushed = 0;
    // Channel A rows {wr, offset, byte}; reads hold the answer
    localparam logic [15:0] ROWS [0:45] = '{16'h0300, 16'h1300,
        16'h110F, 16'h010F, 16'h141F, 16'h041F,
        16'h17A5, 16'h07A5, 16'h02C1, 16'h1205,
        16'h0560, 16'h16FF, 16'h063B,
        16'h1380, 16'h0031, 16'h015C,
        16'h1012, 16'h1134, 16'h0012, 16'h0134, 16'h02C1,
        16'h13BF, 16'h03BF, 16'h1210, 16'h0210,
        16'h11C0, 16'h01C0, 16'h1066, 16'h002D,
        16'h1441, 16'h1542, 16'h1643, 16'h1744,
        16'h0441, 16'h0542, 16'h0643, 16'h0744,
        16'h1380, 16'h12FF, 16'h020F,
        16'h1300, 16'h175A, 16'h072D,
        16'h13BF, 16'h1100, 16'h1300};
    // Revision and identity values are arbitrary
    uart_channel_register_decode #(.REVISION_VALUE(8'h31),
        .IDENTITY_VALUE(8'h5C)) i_uart_channel_register_decode (
        .clk, .rstn, .address_pin, .chan_a_select_n, .chan_b_select_n,
        .read_strobe_n, .write_strobe_n, .data_pin_in, .data_pin_out,
        .data_pin_oe, .rx_char_valid, .rx_char, .rx_char_ready,
        .tx_char_valid, .tx_char, .interrupt_status, .line_status,
        .modem_status, .tx_fill_level, .channel_regs, .fifo_control,
        .fifo_control_load, .fifo_trigger_level, .fifo_trigger_load,
        .extended_mode_select, .extended_mode_load);
    host_bus_model i_host_bus_model (.clk, .data_pin_oe, .data_pin_out,
        .address_pin, .chan_a_select_n, .chan_b_select_n, .read_strobe_n,
        .write_strobe_n, .data_pin_in);
    // Clock; last sent byte
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (tx_char_valid[0] === 1'b1) tx_last <= tx_char[0];
    end
    task automatic finish_test();
        $display("Counts: %0d compared, %0d wrong", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] exp, got);
        comparisons++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask
    // A read that never answers ends the run
    task automatic acc(input logic wr, input logic [1:0] sel_n,
        input logic [2:0] a, input logic [7:0] d);
        logic ok;
        i_host_bus_model.xfer(wr, sel_n, a, d, q, ok);
        if (!ok) begin
            $display("ERROR read answer expected 1 seen 0");
            bad_count++;
            finish_test();
        end
    endtask
    // Reset, table, hand cases
    initial begin
        rstn = 1'b0;
        rx_char_valid = 2'b00;
        rx_char = '0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        check("reset oe", 8'h00, {7'h0, data_pin_oe});
        foreach (ROWS[i]) begin
            acc(ROWS[i][12], 2'b10, ROWS[i][10:8], ROWS[i][7:0]);
            if (!ROWS[i][12]) check("row read", ROWS[i][7:0], q);
        end
        acc(1'b0, 2'b10, 3'h7, 8'h00);
        check("scratch kept", 8'hA5, q);
        check("fcr", 8'h05, fifo_control[0]);
        check("trigger", 8'h66, fifo_trigger_level[0]);
        check("mode select", 8'h5A, extended_mode_select[0]);
        $display("Test register table done");
        acc(1'b1, 2'b10, 3'h0, 8'h9E);
        check("tx byte", 8'h9E, tx_last);
        acc(1'b1, 2'b01, 3'h7, 8'h77);
        acc(1'b1, 2'b00, 3'h7, 8'h99);
        acc(1'b0, 2'b01, 3'h7, 8'h00);
        check("B scratch", 8'h77, q);
        acc(1'b0, 2'b10, 3'h7, 8'h00);
        check("A scratch", 8'hA5, q);
        $display("Test channel selects done");
        rx_char[0] <= 8'h80;
        rx_char_valid[0] <= 1'b1;
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            if (rx_char_ready[0] === 1'b1) pushed++;
            rx_char[0] <= 8'(8'h80 + pushed);
        end
        rx_char_valid[0] <= 1'b0;
        acc(1'b1, 2'b10, 3'h3, 8'hBF);
        acc(1'b0, 2'b10, 3'h0, 8'h00);
        check("level count", 8'h20, q);
        acc(1'b1, 2'b10, 3'h3, 8'h00);
        for (int i = 0; i <= 32; i++) begin
            acc(1'b0, 2'b10, 3'h0, 8'h00);
            check("rx byte", (i < 32) ? 8'(8'h80 + i) : 8'h00, q);
        end
        $display("Test receive buffer done");
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        acc(1'b0, 2'b10, 3'h7, 8'h00);
        check("scratch reset", 8'h00, q);
        $display("Test second reset done");
        finish_test();
    end
endmodule
`default_nettype wire
